// ### rtl/icn_pkg.sv
/*
 * Shared constants and carrier types for the interrupt controller with
 * input change notification.
 * Assumes a 16-bit register port with one-cycle read latency.
 */
package icn_pkg;

    localparam int NSRC = 16;
    localparam int NPIN = 16;
    localparam logic [7:0] VEC_BASE = 8'h08;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_FLAG      = 8'h00;
    localparam logic [7:0] OFF_ENABLE    = 8'h01;
    localparam logic [7:0] OFF_PRIO0     = 8'h02;
    localparam logic [7:0] OFF_PRIO3     = 8'h05;
    localparam logic [7:0] OFF_PEND      = 8'h06;
    localparam logic [7:0] OFF_CPU_STAT  = 8'h07;
    localparam logic [7:0] OFF_CORE_CTRL = 8'h08;
    localparam logic [7:0] OFF_CTRL_ONE  = 8'h09;
    localparam logic [7:0] OFF_CTRL_TWO  = 8'h0a;
    localparam logic [7:0] OFF_CTRL_THR  = 8'h0b;
    localparam logic [7:0] OFF_CTRL_FOUR = 8'h0c;
    localparam logic [7:0] OFF_FLAG_CLR  = 8'h0d;
    localparam logic [7:0] OFF_CN_CTRL   = 8'h10;
    localparam logic [7:0] OFF_CN_EN0    = 8'h11;
    localparam logic [7:0] OFF_CN_EN1    = 8'h12;
    localparam logic [7:0] OFF_CN_STAT   = 8'h13;
    localparam logic [7:0] OFF_CN_FLAG   = 8'h14;
    localparam logic [7:0] OFF_PIN_DIR   = 8'h15;
    localparam logic [7:0] OFF_PIN_STATE = 8'h16;

    // ----------------------------------------------------------------
    // Field positions and masks
    // ----------------------------------------------------------------
    localparam int IPL_LSB       = 5;
    localparam int PRIO_MSB_BIT  = 3;
    localparam int NEST_DIS_BIT  = 15;
    localparam int GIE_BIT       = 15;
    localparam int EXT_POL_BIT   = 0;
    localparam int AUX_PLL_BIT   = 8;
    localparam int LOOP_STK_BIT  = 4;
    localparam int SOFT_HARD_TRAP_FLAG_BIT      = 0;
    localparam int CN_ON_BIT     = 15;
    localparam int CN_STYLE_BIT  = 11;
    localparam logic [15:0] PRIO_MASK = 16'h7777;
    localparam logic [15:0] TRAP_MASK = 16'h007e;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_PRIO = 16'h4444;
    localparam logic [2:0]  RST_IPL  = 3'h0;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } icn_bus_s;

    typedef struct packed {
        logic [7:0] vector;
        logic [3:0] level;
    } icn_vec_s;

endpackage : icn_pkg

// ### rtl/icn_ctrl.sv
/*
 * Interrupt controller with port input change notification.
 * Assumes one clock mclk, synchronous srst, inputs synchronous to mclk,
 * and one-cycle strobes from the register master.
 */
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module icn_ctrl (
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire icn_pkg::icn_bus_s busReq,
    output logic [15:0]           rdata,
    input  wire logic             extIntZero,
    input  wire logic [13:0]      periphReq,
    input  wire logic [5:0]       trapReq,
    input  wire logic             auxPllFail,
    input  wire logic             loopStackOvf,
    input  wire logic             softTrap,
    input  wire logic [15:0]      pins,
    output icn_pkg::icn_vec_s     pendOut,
    output logic                  nestDisable,
    output logic                  cpuIrq
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] srcPrio(input logic [63:0] all,
                                           input int idx);
        srcPrio = all[idx*4 +: 3];
    endfunction : srcPrio

    function automatic logic wrAt(input icn_pkg::icn_bus_s b,
                                  input logic [7:0] off);
        wrAt = b.wr && (b.addr == off);
    endfunction : wrAt

    logic [15:0] flag_reg;
    logic [15:0] enable_reg;
    logic [63:0] prio_reg;
    icn_pkg::icn_vec_s pend_reg;
    logic [2:0]  ipl_reg;
    logic [15:0] ctrlOne_reg;
    logic [15:0] ctrlTwo_reg;
    logic [15:0] ctrlThr_reg;
    logic [15:0] ctrlFour_reg;
    logic [15:0] cnCtrl_reg;
    logic [15:0] cnEn0_reg;
    logic [15:0] cnEn1_reg;
    logic [15:0] cnStat_reg;
    logic [15:0] cnFlag_reg;
    logic [15:0] pinDir_reg;
    logic [15:0] lastRead_reg;
    logic [15:0] pinPrev_reg;
    logic        extPrev_reg;
    logic [15:0] rdata_reg;

    logic [15:0] flagSet;
    logic [15:0] reqVec;
    logic [3:0]  curLevel;
    logic        prioMsb;
    logic        extEdge;
    logic [15:0] cnRise;
    logic [15:0] cnFall;
    logic [15:0] cnSel;
    logic        cnNew;
    logic        cnOn;
    logic        pinRead;
    logic [3:0]  bestIdx;
    logic [3:0]  bestLvl;
    logic        anyReq;

    // ----------------------------------------------------------------
    // Source requests and flags
    // ----------------------------------------------------------------
    assign extEdge = ctrlTwo_reg[icn_pkg::EXT_POL_BIT]
                   ? (extPrev_reg && !extIntZero)
                   : (!extPrev_reg && extIntZero);
    assign flagSet = {periphReq, cnNew, extEdge};

    always_ff @(posedge mclk) begin
        if (srst) begin
            extPrev_reg <= 1'b0;
        end else begin
            extPrev_reg <= extIntZero;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            flag_reg <= icn_pkg::RST_ZERO;
        end else if (wrAt(busReq, icn_pkg::OFF_FLAG_CLR)) begin
            flag_reg <= (flag_reg & ~busReq.wdata) | flagSet;
        end else begin
            flag_reg <= flag_reg | flagSet;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            enable_reg <= icn_pkg::RST_ZERO;
        end else if (wrAt(busReq, icn_pkg::OFF_ENABLE)) begin
            enable_reg <= busReq.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            prio_reg <= {4{icn_pkg::RST_PRIO}};
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (wrAt(busReq, icn_pkg::OFF_PRIO0 + 8'(k))) begin
                    prio_reg[k*16 +: 16] <=
                        busReq.wdata & icn_pkg::PRIO_MASK;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // CPU level and trap control
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            ipl_reg <= icn_pkg::RST_IPL;
        end else if (wrAt(busReq, icn_pkg::OFF_CPU_STAT)) begin
            ipl_reg <= busReq.wdata[icn_pkg::IPL_LSB +: 3];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrlOne_reg <= icn_pkg::RST_ZERO;
        end else if (wrAt(busReq, icn_pkg::OFF_CTRL_ONE)) begin
            ctrlOne_reg <= (busReq.wdata &
                            (icn_pkg::TRAP_MASK | 16'h8000))
                         | {9'h000, trapReq, 1'b0};
        end else begin
            ctrlOne_reg <= ctrlOne_reg | {9'h000, trapReq, 1'b0};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrlTwo_reg <= icn_pkg::RST_ZERO;
        end else if (wrAt(busReq, icn_pkg::OFF_CTRL_TWO)) begin
            ctrlTwo_reg <= busReq.wdata & 16'h8001;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrlThr_reg  <= icn_pkg::RST_ZERO;
            ctrlFour_reg <= icn_pkg::RST_ZERO;
        end else begin
            if (wrAt(busReq, icn_pkg::OFF_CTRL_THR)) begin
                ctrlThr_reg <= (busReq.wdata & 16'h0110)
                             | {7'h00, auxPllFail, 3'h0,
                                loopStackOvf, 4'h0};
            end else begin
                ctrlThr_reg <= ctrlThr_reg
                             | {7'h00, auxPllFail, 3'h0,
                                loopStackOvf, 4'h0};
            end
            if (wrAt(busReq, icn_pkg::OFF_CTRL_FOUR)) begin
                ctrlFour_reg <= (busReq.wdata & 16'h0001)
                              | {15'h0000, softTrap};
            end else begin
                ctrlFour_reg <= ctrlFour_reg | {15'h0000, softTrap};
            end
        end
    end

    assign prioMsb  = |(ctrlOne_reg & icn_pkg::TRAP_MASK)
                    | ctrlThr_reg[icn_pkg::AUX_PLL_BIT]
                    | ctrlThr_reg[icn_pkg::LOOP_STK_BIT]
                    | ctrlFour_reg[icn_pkg::SOFT_HARD_TRAP_FLAG_BIT];
    assign curLevel = {prioMsb, ipl_reg};
    assign nestDisable = ctrlOne_reg[icn_pkg::NEST_DIS_BIT];

    // ----------------------------------------------------------------
    // Arbitration
    // ----------------------------------------------------------------
    always_comb begin
        reqVec  = '0;
        bestIdx = 4'h0;
        bestLvl = 4'h0;
        anyReq  = 1'b0;
        for (int i = 0; i < icn_pkg::NSRC; i++) begin
            reqVec[i] = flag_reg[i] && enable_reg[i]
                      && ctrlTwo_reg[icn_pkg::GIE_BIT]
                      && ({1'b0, srcPrio(prio_reg, i)} > curLevel);
            if (reqVec[i] && ({1'b0, srcPrio(prio_reg, i)} > bestLvl)) begin
                bestIdx = 4'(i);
                bestLvl = {1'b0, srcPrio(prio_reg, i)};
                anyReq  = 1'b1;
            end
        end
    end

    assign cpuIrq = anyReq;

    always_ff @(posedge mclk) begin
        if (srst) begin
            pend_reg <= '0;
        end else if (anyReq) begin
            pend_reg.vector <= icn_pkg::VEC_BASE + {4'h0, bestIdx};
            pend_reg.level  <= bestLvl;
        end
    end

    assign pendOut = pend_reg;

    // ----------------------------------------------------------------
    // Change notification
    // ----------------------------------------------------------------
    assign cnOn    = cnCtrl_reg[icn_pkg::CN_ON_BIT];
    assign pinRead = busReq.rd && (busReq.addr == icn_pkg::OFF_PIN_STATE);
    assign cnRise  = pins & ~pinPrev_reg;
    assign cnFall  = ~pins & pinPrev_reg;

    always_comb begin
        if (cnCtrl_reg[icn_pkg::CN_STYLE_BIT]) begin
            cnSel = (cnEn0_reg & ~cnEn1_reg & cnRise)
                  | (~cnEn0_reg & cnEn1_reg & cnFall)
                  | (cnEn0_reg & cnEn1_reg & (cnRise | cnFall));
        end else begin
            cnSel = cnEn0_reg & (pins ^ lastRead_reg);
        end
        cnSel = cnSel & pinDir_reg & {16{cnOn}};
    end

    assign cnNew = |(cnSel & ~cnFlag_reg);

    always_ff @(posedge mclk) begin
        if (srst) begin
            pinPrev_reg  <= icn_pkg::RST_ZERO;
            lastRead_reg <= icn_pkg::RST_ZERO;
        end else begin
            pinPrev_reg <= pins;
            if (pinRead) begin
                lastRead_reg <= pins;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnStat_reg <= icn_pkg::RST_ZERO;
        end else begin
            cnStat_reg <= (pinRead ? icn_pkg::RST_ZERO : cnStat_reg)
                        | ((pins ^ pinPrev_reg) & {16{cnOn}});
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnFlag_reg <= icn_pkg::RST_ZERO;
        end else if (wrAt(busReq, icn_pkg::OFF_CN_FLAG)) begin
            cnFlag_reg <= (cnFlag_reg & ~busReq.wdata) | cnSel;
        end else begin
            cnFlag_reg <= cnFlag_reg | cnSel;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnCtrl_reg <= icn_pkg::RST_ZERO;
            cnEn0_reg  <= icn_pkg::RST_ZERO;
            cnEn1_reg  <= icn_pkg::RST_ZERO;
            pinDir_reg <= 16'hffff;
        end else begin
            if (wrAt(busReq, icn_pkg::OFF_CN_CTRL)) begin
                cnCtrl_reg <= busReq.wdata & 16'h8800;
            end
            if (wrAt(busReq, icn_pkg::OFF_CN_EN0)) begin
                cnEn0_reg <= busReq.wdata;
            end
            if (wrAt(busReq, icn_pkg::OFF_CN_EN1)) begin
                cnEn1_reg <= busReq.wdata;
            end
            if (wrAt(busReq, icn_pkg::OFF_PIN_DIR)) begin
                pinDir_reg <= busReq.wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= icn_pkg::RST_ZERO;
        end else if (!busReq.rd) begin
            rdata_reg <= icn_pkg::RST_ZERO;
        end else if (busReq.addr == icn_pkg::OFF_FLAG) begin
            rdata_reg <= flag_reg;
        end else if (busReq.addr == icn_pkg::OFF_ENABLE) begin
            rdata_reg <= enable_reg;
        end else if (busReq.addr >= icn_pkg::OFF_PRIO0
                     && busReq.addr <= icn_pkg::OFF_PRIO3) begin
            rdata_reg <= prio_reg[(busReq.addr[1:0] ^ 2'h2)*16 +: 16];
        end else if (busReq.addr == icn_pkg::OFF_PEND) begin
            rdata_reg <= {4'h0, pend_reg.level, pend_reg.vector};
        end else if (busReq.addr == icn_pkg::OFF_CPU_STAT) begin
            rdata_reg <= {8'h00, ipl_reg, 5'h00};
        end else if (busReq.addr == icn_pkg::OFF_CORE_CTRL) begin
            rdata_reg <= {12'h000, prioMsb, 3'h0};
        end else if (busReq.addr == icn_pkg::OFF_CTRL_ONE) begin
            rdata_reg <= ctrlOne_reg;
        end else if (busReq.addr == icn_pkg::OFF_CTRL_TWO) begin
            rdata_reg <= ctrlTwo_reg;
        end else if (busReq.addr == icn_pkg::OFF_CTRL_THR) begin
            rdata_reg <= ctrlThr_reg;
        end else if (busReq.addr == icn_pkg::OFF_CTRL_FOUR) begin
            rdata_reg <= ctrlFour_reg;
        end else if (busReq.addr == icn_pkg::OFF_CN_CTRL) begin
            rdata_reg <= cnCtrl_reg;
        end else if (busReq.addr == icn_pkg::OFF_CN_EN0) begin
            rdata_reg <= cnEn0_reg;
        end else if (busReq.addr == icn_pkg::OFF_CN_EN1) begin
            rdata_reg <= cnEn1_reg;
        end else if (busReq.addr == icn_pkg::OFF_CN_STAT) begin
            rdata_reg <= cnStat_reg;
        end else if (busReq.addr == icn_pkg::OFF_CN_FLAG) begin
            rdata_reg <= cnFlag_reg;
        end else if (busReq.addr == icn_pkg::OFF_PIN_DIR) begin
            rdata_reg <= pinDir_reg;
        end else if (busReq.addr == icn_pkg::OFF_PIN_STATE) begin
            rdata_reg <= pins;
        end else begin
            rdata_reg <= icn_pkg::RST_ZERO;
        end
    end

    assign rdata = rdata_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    AST_FLAG_SET: assert property (periphReq[0] |=> flag_reg[2])
        else $error("peripheral request did not set its flag");
    AST_FLAG_HOLD: assert property (flag_reg[3]
        && !(wrAt(busReq, icn_pkg::OFF_FLAG_CLR) && busReq.wdata[3])
        |=> flag_reg[3])
        else $error("flag cleared without software write");
    AST_IRQ_EN: assert property (cpuIrq |-> |(flag_reg & enable_reg))
        else $error("request without enabled flag");
    AST_IRQ_GIE: assert property (!ctrlTwo_reg[icn_pkg::GIE_BIT]
        |-> !cpuIrq)
        else $error("request while globally disabled");
    AST_PEND_LVL: assert property (cpuIrq |=> pend_reg.level
        > $past(curLevel))
        else $error("latched level not above cpu level");
    AST_IPL_WR: assert property (wrAt(busReq, icn_pkg::OFF_CPU_STAT)
        |=> ipl_reg == $past(busReq.wdata[7:5]))
        else $error("cpu level write lost");
    AST_TRAP_MSB: assert property (softTrap |=> curLevel[3] [*2])
        else $error("trap did not raise level msb");
    AST_CN_OFF: assert property (!cnOn |-> cnSel == 16'h0000)
        else $error("notification while port off");
    AST_CN_DIR: assert property (!pinDir_reg[0] && !cnFlag_reg[0]
        |=> !cnFlag_reg[0])
        else $error("output pin raised notification");
    AST_CN_STAT: assert property (pinRead && pins == pinPrev_reg
        |=> cnStat_reg == 16'h0000)
        else $error("change status not cleared by read");

    COV_IRQ: cover property (cpuIrq ##1 pend_reg.vector == 8'h0a);
    COV_CN_EDGE: cover property (cnCtrl_reg[icn_pkg::CN_STYLE_BIT]
        && cnNew ##[1:3] cpuIrq);
    COV_TRAP: cover property (softTrap ##1 curLevel[3]);

endmodule : icn_ctrl

// ### verif/icn_partner.sv
/*
 * Partner model: interrupting peripherals, trap sources and port pins.
 * Assumes bench commands that change right after mclk rises.
 */
`timescale 1ns/1ps
module icn_partner (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [22:0] evIn,
    input  wire logic        extIn,
    input  wire logic [15:0] pinIn,
    output logic [13:0]      periphReq,
    output logic [5:0]       trapReq,
    output logic             auxPllFail,
    output logic             loopStackOvf,
    output logic             softTrap,
    output logic             extIntZero,
    output logic [15:0]      pins
);
    // ----------------------------------------------------------------
    // Registered event and pin drive
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            {softTrap, loopStackOvf, auxPllFail, trapReq, periphReq} <= '0;
            extIntZero <= 1'b0;
            pins       <= 16'h0000;
        end else begin
            {softTrap, loopStackOvf, auxPllFail, trapReq, periphReq} <= evIn;
            extIntZero <= extIn;
            pins       <= pinIn;
        end
    end
endmodule : icn_partner

// ### verif/icn_ctrl_tb_top.sv
/*
 * Self-checking bench for the interrupt controller.
 * Assumes the package offsets and the one-cycle read latency.
 */
`timescale 1ns/1ps
module icn_ctrl_tb_top;
    logic              mclk;
    logic              srst;
    icn_pkg::icn_bus_s busReq;
    logic [15:0]       rdata;
    icn_pkg::icn_vec_s pendOut;
    logic              nestDisable;
    logic              cpuIrq;
    logic [13:0]       periphReq;
    logic [5:0]        trapReq;
    logic              auxPllFail;
    logic              loopStackOvf;
    logic              softTrap;
    logic              extIntZero;
    logic [15:0]       pins;
    logic [22:0]       evIn;
    logic              extIn;
    logic [15:0]       pinIn;
    int                n_mismatch;
    int                num_checks;

    icn_ctrl i_icn_ctrl (.mclk(mclk), .srst(srst), .busReq(busReq),
        .rdata(rdata), .extIntZero(extIntZero), .periphReq(periphReq),
        .trapReq(trapReq), .auxPllFail(auxPllFail),
        .loopStackOvf(loopStackOvf), .softTrap(softTrap), .pins(pins),
        .pendOut(pendOut), .nestDisable(nestDisable), .cpuIrq(cpuIrq));
    icn_partner i_icn_partner (.mclk(mclk), .srst(srst), .evIn(evIn),
        .extIn(extIn), .pinIn(pinIn), .periphReq(periphReq),
        .trapReq(trapReq), .auxPllFail(auxPllFail),
        .loopStackOvf(loopStackOvf), .softTrap(softTrap),
        .extIntZero(extIntZero), .pins(pins));

    // ----------------------------------------------------------------
    // Clock, verdict and tasks
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic test_done;
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk) busReq <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
        @(posedge mclk) busReq.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk) busReq <= '{addr:a, wdata:16'h0, wr:1'b0, rd:1'b1};
        @(posedge mclk) busReq.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rchk
    task automatic ev(input logic [22:0] m);
        @(posedge mclk) evIn <= m;
        @(posedge mclk) evIn <= '0;
        tick(3);
    endtask : ev
    task automatic pin(input logic [15:0] v);
        @(posedge mclk) pinIn <= v;
        tick(4);
    endtask : pin
    task automatic clr;
        wr(icn_pkg::OFF_CN_FLAG, 16'hffff);
        wr(icn_pkg::OFF_FLAG_CLR, 16'hffff);
    endtask : clr

    initial begin
        #300000;
        n_mismatch++;
        test_done();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        num_checks = 0;
        srst = 1'b1;
        busReq = '0;
        evIn = '0;
        extIn = 1'b0;
        pinIn = 16'h0000;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        rchk(icn_pkg::OFF_FLAG, 16'h0000);
        rchk(icn_pkg::OFF_PRIO0, 16'h4444);
        rchk(icn_pkg::OFF_PIN_DIR, 16'hffff);
        rchk(8'h3f, 16'h0000);
        wr(icn_pkg::OFF_ENABLE, 16'hffff);
        wr(icn_pkg::OFF_CTRL_TWO, 16'h8000);
        ev(23'h1);
        chk({15'h0, cpuIrq}, 16'h1);
        chk({4'h0, pendOut}, 16'h0a4);
        wr(icn_pkg::OFF_FLAG, 16'h0000);
        rchk(icn_pkg::OFF_FLAG, 16'h0004);
        @(posedge mclk) extIn <= 1'b1;
        tick(4);
        chk({4'h0, pendOut}, 16'h084);
        wr(icn_pkg::OFF_FLAG_CLR, 16'h0001);
        @(posedge mclk) extIn <= 1'b0;
        wr(icn_pkg::OFF_CPU_STAT, 16'h0080);
        rchk(icn_pkg::OFF_CPU_STAT, 16'h0080);
        chk({15'h0, cpuIrq}, 16'h0);
        wr(icn_pkg::OFF_PRIO0, 16'h4544);
        tick(2);
        chk({4'h0, pendOut}, 16'h0a5);
        wr(icn_pkg::OFF_ENABLE, 16'hfffb);
        chk({15'h0, cpuIrq}, 16'h0);
        wr(icn_pkg::OFF_ENABLE, 16'hffff);
        wr(icn_pkg::OFF_CTRL_TWO, 16'h0000);
        chk({15'h0, cpuIrq}, 16'h0);
        wr(icn_pkg::OFF_CTRL_TWO, 16'h8000);
        ev(23'h1 << 19);
        rchk(icn_pkg::OFF_CTRL_ONE, 16'h0040);
        wr(icn_pkg::OFF_CORE_CTRL, 16'h0000);
        rchk(icn_pkg::OFF_CORE_CTRL, 16'h0008);
        chk({15'h0, cpuIrq}, 16'h0);
        wr(icn_pkg::OFF_CTRL_ONE, 16'h8000);
        chk({15'h0, nestDisable}, 16'h1);
        chk({15'h0, cpuIrq}, 16'h1);
        wr(icn_pkg::OFF_CTRL_ONE, 16'h0000);
        wr(icn_pkg::OFF_CPU_STAT, 16'h0000);
        wr(icn_pkg::OFF_CN_CTRL, 16'h8800);
        clr();
        for (int m = 0; m < 4; m++) begin
            wr(icn_pkg::OFF_CN_EN0, {15'h0, m[0]});
            wr(icn_pkg::OFF_CN_EN1, {15'h0, m[1]});
            pin(16'h0001);
            rchk(icn_pkg::OFF_CN_FLAG, {15'h0, m[0]});
            rchk(icn_pkg::OFF_FLAG, {14'h0, m[0], 1'b0});
            clr();
            pin(16'h0000);
            rchk(icn_pkg::OFF_CN_FLAG, {15'h0, m[1]});
            clr();
        end
        wr(icn_pkg::OFF_CN_CTRL, 16'h0800);
        pin(16'h0001);
        rchk(icn_pkg::OFF_CN_FLAG, 16'h0000);
        pin(16'h0000);
        wr(icn_pkg::OFF_CN_CTRL, 16'h8800);
        wr(icn_pkg::OFF_PIN_DIR, 16'hfffe);
        pin(16'h0001);
        rchk(icn_pkg::OFF_CN_FLAG, 16'h0000);
        pin(16'h0000);
        wr(icn_pkg::OFF_PIN_DIR, 16'hffff);
        wr(icn_pkg::OFF_CN_CTRL, 16'h8000);
        wr(icn_pkg::OFF_CN_EN1, 16'h0000);
        rchk(icn_pkg::OFF_PIN_STATE, 16'h0000);
        pin(16'h0001);
        rchk(icn_pkg::OFF_CN_STAT, 16'h0001);
        rchk(icn_pkg::OFF_CN_FLAG, 16'h0001);
        rchk(icn_pkg::OFF_PIN_STATE, 16'h0001);
        rchk(icn_pkg::OFF_CN_STAT, 16'h0000);
        clr();
        wr(icn_pkg::OFF_CN_EN0, 16'h0000);
        wr(icn_pkg::OFF_CN_EN1, 16'h0001);
        pin(16'h0000);
        rchk(icn_pkg::OFF_CN_FLAG, 16'h0000);
        ev(23'h7 << 20);
        rchk(icn_pkg::OFF_CTRL_THR, 16'h0110);
        rchk(icn_pkg::OFF_CTRL_FOUR, 16'h0001);
        wr(icn_pkg::OFF_CTRL_TWO, 16'h8001);
        wr(icn_pkg::OFF_FLAG_CLR, 16'hffff);
        @(posedge mclk) extIn <= 1'b1;
        tick(4);
        rchk(icn_pkg::OFF_FLAG, 16'h0000);
        @(posedge mclk) extIn <= 1'b0;
        tick(4);
        rchk(icn_pkg::OFF_FLAG, 16'h0001);
        test_done();
    end
endmodule : icn_ctrl_tb_top
